/* design/ldo2_pkg.sv */
// shared types and constants for the regulator enable and fault control block
package ldo2_pkg;

    // register bus geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;

    // register offsets
    localparam logic [ADDR_W-1:0] OFS_CTRL   = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_VOLT   = 8'h01;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h02;
    localparam logic [ADDR_W-1:0] OFS_MASK   = 8'h03;
    localparam logic [ADDR_W-1:0] OFS_STATE  = 8'h04;

    // voltage code and set-point decode, in millivolts
    localparam int CODE_W       = 4;
    localparam int MV_W         = 12;
    localparam int VOLT_BASE_MV = 1800;
    localparam int VOLT_STEP_MV = 100;

    // device power state, driven by the surrounding state machine
    typedef enum logic [1:0] {
        PS_RUN,
        PS_STANDBY,
        PS_SLEEP
    } power_state_t;

    // control register layout, lsb first is reg_enable
    typedef struct packed {
        logic short_protect_enable;
        logic low_power_select;
        logic sleep_keep_on;
        logic standby_keep_on;
        logic reg_enable;
    } ctrl_t;

    localparam int    CTRL_W     = $bits(ctrl_t);
    localparam ctrl_t CTRL_RESET = ctrl_t'(5'h00);

    // status and mask layout: one event bit
    localparam int IRQ_BIT_OC = 0;

    // regulator drive bundle toward the analog side
    typedef struct packed {
        logic reg_on;
        logic low_power_mode;
        logic discharge_on;
    } drive_t;

    localparam drive_t DRIVE_RESET = drive_t'(3'h1);

endpackage

/* design/pin_sync.sv */
// three-flop input synchroniser with agreement filter
`timescale 1ns/10ps
module pin_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             ref_clk,
    input  wire logic             rst,
    input  wire logic             ce,
    input  wire logic [WIDTH-1:0] pin_in,
    output logic      [WIDTH-1:0] level
);

    // a zero-width synchroniser has nothing to carry
    if (WIDTH < 1) begin : g_bad_width
        $error("pin_sync: WIDTH must be at least 1");
    end

    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;

    // the first stage feeds only the second, never any logic
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            s1    <= '0;
            s2    <= '0;
            s3    <= '0;
            level <= '0;
        end else if (ce) begin
            s1 <= pin_in;
            s2 <= s1;
            s3 <= s2;
            for (int i = 0; i < WIDTH; i++) begin
                if (s2[i] == s3[i]) begin
                    level[i] <= s3[i];
                end
            end
        end
    end

endmodule // pin_sync

/* design/voltage_decode.sv */
// linear decode of the voltage code into a millivolt set-point
`timescale 1ns/10ps
module voltage_decode #(
    parameter int CODE_W = ldo2_pkg::CODE_W,
    parameter int MV_W   = ldo2_pkg::MV_W
) (
    input  wire logic              ref_clk,
    input  wire logic              rst,
    input  wire logic              ce,
    input  wire logic [CODE_W-1:0] voltage_code,
    output logic      [MV_W-1:0]   setpoint_mv
);

    localparam int TOP_MV = ldo2_pkg::VOLT_BASE_MV + ldo2_pkg::VOLT_STEP_MV * ((1 << CODE_W) - 1);

    // refuse a result width that cannot hold the top set-point
    if (TOP_MV >= (1 << MV_W)) begin : g_bad_width
        $error("voltage_decode: MV_W too small for the code range");
    end

    wire logic [MV_W-1:0] next_setpoint_mv;

    assign next_setpoint_mv = MV_W'(ldo2_pkg::VOLT_BASE_MV + ldo2_pkg::VOLT_STEP_MV * int'(voltage_code));

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            setpoint_mv <= MV_W'(ldo2_pkg::VOLT_BASE_MV);
        end else if (ce) begin
            setpoint_mv <= next_setpoint_mv;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    property p_linear_code;
        ce && voltage_code == 4'h0 |=> setpoint_mv == 12'h708;
    endproperty
    a_linear_code: assert property (p_linear_code) else $error("code zero is not 1800 mV");

    property p_top_code;
        ce && voltage_code == 4'hf |=> setpoint_mv == 12'hce4;
    endproperty
    a_top_code: assert property (p_top_code) else $error("code fifteen is not 3300 mV");

endmodule // voltage_decode

/* design/ldo2_enable_fault_control.sv */
// enable, low-power, discharge and overcurrent fault control of the 400 mA regulator
`timescale 1ns/10ps
// Operation
// - in run, output follows the enable bit, other bits ignored
// - standby needs enable and standby bit; sleep needs enable and sleep bit
// - low-power mode only when on in standby or sleep with low-power bit
// - voltage code maps linearly, 1.80 V at zero, 0.10 V per step
// - discharge pull-down on when disabled or processor reset output low
// - overcurrent with protection set clears enable and raises fault flag
// - without protection overcurrent keeps regulator on; protection resets to zero
// - fault flag raised on every overload regardless of protection
// - mask bit keeps fault flag off the interrupt output
module ldo2_enable_fault_control (
    input  wire logic                          ref_clk,
    input  wire logic                          rst,
    input  wire logic                          ce,
    input  wire logic [ldo2_pkg::ADDR_W-1:0]   addr,
    input  wire logic [ldo2_pkg::DATA_W-1:0]   wdata,
    input  wire logic                          wr,
    input  wire logic                          rd,
    output logic      [ldo2_pkg::DATA_W-1:0]   rdata,
    input  wire ldo2_pkg::power_state_t        power_state,
    input  wire logic                          processor_reset_out_n,
    input  wire logic                          overcurrent_pin,
    output ldo2_pkg::drive_t                   drive,
    output logic      [ldo2_pkg::CODE_W-1:0]   voltage_code,
    output logic      [ldo2_pkg::MV_W-1:0]     setpoint_mv,
    output logic                               irq
);

    ldo2_pkg::ctrl_t             ctrl;
    logic                        overcurrent_irq;
    logic                        overcurrent_irq_mask;
    logic                        oc_level;
    logic                        oc_prev;
    logic [ldo2_pkg::DATA_W-1:0] next_rdata;
    ldo2_pkg::drive_t            next_drive;

    // comparator output is asynchronous to ref_clk
    pin_sync #(
        .WIDTH (1)
    ) u_oc_sync (
        .ref_clk (ref_clk),
        .rst     (rst),
        .ce      (ce),
        .pin_in  (overcurrent_pin),
        .level   (oc_level)
    );

    voltage_decode #(
        .CODE_W (ldo2_pkg::CODE_W),
        .MV_W   (ldo2_pkg::MV_W)
    ) u_vdec (
        .ref_clk      (ref_clk),
        .rst          (rst),
        .ce           (ce),
        .voltage_code (voltage_code),
        .setpoint_mv  (setpoint_mv)
    );

    // address decode
    wire logic sel_ctrl   = addr == ldo2_pkg::OFS_CTRL;
    wire logic sel_volt   = addr == ldo2_pkg::OFS_VOLT;
    wire logic sel_status = addr == ldo2_pkg::OFS_STATUS;
    wire logic sel_mask   = addr == ldo2_pkg::OFS_MASK;
    wire logic sel_state  = addr == ldo2_pkg::OFS_STATE;

    wire logic wr_ctrl    = wr && sel_ctrl;
    wire logic wr_volt    = wr && sel_volt;
    wire logic wr_mask    = wr && sel_mask;
    wire logic clr_oc     = wr && sel_status && wdata[ldo2_pkg::IRQ_BIT_OC];

    // one event per overload, counted at the rising edge of the filtered level
    wire logic oc_event   = oc_level && !oc_prev;

    // protection trips the enable in the event cycle itself
    wire logic trip       = oc_event && ctrl.short_protect_enable;

    // fault trip beats a software write of the enable bit in the same cycle
    wire ldo2_pkg::ctrl_t wctrl = ldo2_pkg::ctrl_t'(wdata[ldo2_pkg::CTRL_W-1:0]);
    wire logic next_enable = trip ? 1'b0 : (wr_ctrl ? wctrl.reg_enable : ctrl.reg_enable);

    logic want_on;
    logic lp_allowed;
    always_comb begin
        want_on    = 1'b0;
        lp_allowed = 1'b0;
        unique case (power_state)
            ldo2_pkg::PS_RUN: begin
                want_on = ctrl.reg_enable;
            end
            ldo2_pkg::PS_STANDBY: begin
                want_on    = ctrl.reg_enable && ctrl.standby_keep_on;
                lp_allowed = 1'b1;
            end
            ldo2_pkg::PS_SLEEP: begin
                want_on    = ctrl.reg_enable && ctrl.sleep_keep_on;
                lp_allowed = 1'b1;
            end
            default: begin
                want_on    = 1'b0;
                lp_allowed = 1'b0;
            end
        endcase
    end

    // a trip turns the output off without waiting for the enable register
    assign next_drive.reg_on = want_on && !trip;
    assign next_drive.low_power_mode = next_drive.reg_on && lp_allowed && ctrl.low_power_select;
    // pull-down while off or processor held in reset
    assign next_drive.discharge_on = !next_drive.reg_on || !processor_reset_out_n;

    // mask gates the sticky flag onto the line
    assign irq = overcurrent_irq && !overcurrent_irq_mask;

    // read mux, unmapped offsets read zero
    always_comb begin
        next_rdata = '0;
        if (rd) begin
            if (sel_ctrl) begin
                next_rdata[ldo2_pkg::CTRL_W-1:0] = ctrl;
            end else if (sel_volt) begin
                next_rdata[ldo2_pkg::CODE_W-1:0] = voltage_code;
            end else if (sel_status) begin
                next_rdata[ldo2_pkg::IRQ_BIT_OC] = overcurrent_irq;
            end else if (sel_mask) begin
                next_rdata[ldo2_pkg::IRQ_BIT_OC] = overcurrent_irq_mask;
            end else if (sel_state) begin
                next_rdata[$bits(ldo2_pkg::drive_t)-1:0] = drive;
                next_rdata[$bits(ldo2_pkg::drive_t)]     = oc_level;
            end
        end
    end

    // control register; protection bit resets clear
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ctrl <= ldo2_pkg::CTRL_RESET;
        end else if (ce) begin
            if (wr_ctrl) begin
                ctrl <= wctrl;
            end
            ctrl.reg_enable <= next_enable;
        end
    end

    // voltage code and mask
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            voltage_code         <= '0;
            overcurrent_irq_mask <= 1'b0;
        end else if (ce) begin
            if (wr_volt) begin
                voltage_code <= wdata[ldo2_pkg::CODE_W-1:0];
            end
            if (wr_mask) begin
                overcurrent_irq_mask <= wdata[ldo2_pkg::IRQ_BIT_OC];
            end
        end
    end

    // sticky fault flag, set wins over write-one-clear
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            overcurrent_irq <= 1'b0;
            oc_prev         <= 1'b0;
        end else if (ce) begin
            oc_prev         <= oc_level;
            overcurrent_irq <= oc_event || (overcurrent_irq && !clr_oc);
        end
    end

    // drive outputs and read data are registered
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            drive <= ldo2_pkg::DRIVE_RESET;
            rdata <= '0;
        end else if (ce) begin
            drive <= next_drive;
            rdata <= next_rdata;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    property p_run_follow;
        ce && power_state == ldo2_pkg::PS_RUN && !trip |=> drive.reg_on == $past(ctrl.reg_enable);
    endproperty
    a_run_follow: assert property (p_run_follow) else $error("run state output differs from enable");

    property p_standby_on;
        ce && power_state == ldo2_pkg::PS_STANDBY |=>
            drive.reg_on == $past(ctrl.reg_enable && ctrl.standby_keep_on && !trip);
    endproperty
    a_standby_on: assert property (p_standby_on) else $error("standby output decision wrong");

    property p_sleep_on;
        ce && power_state == ldo2_pkg::PS_SLEEP |=>
            drive.reg_on == $past(ctrl.reg_enable && ctrl.sleep_keep_on && !trip);
    endproperty
    a_sleep_on: assert property (p_sleep_on) else $error("sleep output decision wrong");

    property p_low_power;
        ce |=> drive.low_power_mode == ($past(power_state != ldo2_pkg::PS_RUN && ctrl.low_power_select)
                                        && drive.reg_on);
    endproperty
    a_low_power: assert property (p_low_power) else $error("low-power mode wrong");

    property p_discharge;
        ce |=> drive.discharge_on == (!drive.reg_on || !$past(processor_reset_out_n));
    endproperty
    a_discharge: assert property (p_discharge) else $error("discharge pull-down wrong");

    property p_trip;
        ce && trip |=> !ctrl.reg_enable && overcurrent_irq && !drive.reg_on;
    endproperty
    a_trip: assert property (p_trip) else $error("protected overcurrent did not trip");

    property p_no_trip;
        ce && oc_event && !ctrl.short_protect_enable && !wr_ctrl |=> ctrl.reg_enable == $past(ctrl.reg_enable);
    endproperty
    a_no_trip: assert property (p_no_trip) else $error("unprotected overcurrent changed enable");

    property p_flag_set;
        ce && oc_event |=> overcurrent_irq;
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("overload did not set fault flag");

    property p_mask;
        overcurrent_irq_mask |-> !irq;
    endproperty
    a_mask: assert property (p_mask) else $error("masked fault reached irq");

    property p_sticky;
        overcurrent_irq && !(ce && clr_oc) |=> overcurrent_irq;
    endproperty
    a_sticky: assert property (p_sticky) else $error("fault flag dropped without clear");

    property p_read_once;
        ce && rd ##1 ce && !rd |=> rdata == '0;
    endproperty
    a_read_once: assert property (p_read_once) else $error("read data stood past its cycle");

    // corner cases that the per-state checks above leave open
    property p_illegal_off;
        ce && power_state != ldo2_pkg::PS_RUN && power_state != ldo2_pkg::PS_STANDBY
            && power_state != ldo2_pkg::PS_SLEEP |=> !drive.reg_on;
    endproperty
    a_illegal_off: assert property (p_illegal_off) else $error("undefined power state left output on");

    property p_run_no_lp;
        ce && power_state == ldo2_pkg::PS_RUN |=> !drive.low_power_mode;
    endproperty
    a_run_no_lp: assert property (p_run_no_lp) else $error("low-power mode active in run");

    property p_hold_discharge;
        ce && !processor_reset_out_n |=> drive.discharge_on;
    endproperty
    a_hold_discharge: assert property (p_hold_discharge) else $error("pull-down off in reset");

    property p_trip_beats_write;
        ce && trip && wr_ctrl |=> !ctrl.reg_enable;
    endproperty
    a_trip_beats_write: assert property (p_trip_beats_write) else $error("enable write beat a trip");

    property p_limit_stays_on;
        ce && oc_event && !ctrl.short_protect_enable && !wr_ctrl && want_on |=> drive.reg_on;
    endproperty
    a_limit_stays_on: assert property (p_limit_stays_on) else $error("unprotected fault cut output");

    property p_protect_hold;
        ce && !wr_ctrl |=> ctrl.short_protect_enable == $past(ctrl.short_protect_enable);
    endproperty
    a_protect_hold: assert property (p_protect_hold) else $error("protection bit moved without write");

    property p_set_wins;
        ce && oc_event && clr_oc |=> overcurrent_irq;
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("clear beat a new fault");

    property p_clear;
        ce && clr_oc && !oc_event |=> !overcurrent_irq;
    endproperty
    a_clear: assert property (p_clear) else $error("fault flag not cleared by write");

    property p_irq_level;
        overcurrent_irq && !overcurrent_irq_mask |-> irq;
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("unmasked fault missing on irq");

    property p_volt_write;
        ce && wr_volt |=> voltage_code == $past(wdata[ldo2_pkg::CODE_W-1:0]);
    endproperty
    a_volt_write: assert property (p_volt_write) else $error("voltage code write lost");

    // a frozen block must not move its outputs, or software sees a half-applied write
    property p_freeze;
        !ce |=> drive == $past(drive) && ctrl == $past(ctrl) && rdata == $past(rdata);
    endproperty
    a_freeze: assert property (p_freeze) else $error("state moved with clock enable low");

    c_trip: cover property (ce && trip ##1 irq);
    c_standby_lp: cover property (drive.low_power_mode && power_state == ldo2_pkg::PS_STANDBY);
    c_limit_on: cover property (ce && oc_event && !ctrl.short_protect_enable && drive.reg_on);
    c_clear: cover property (overcurrent_irq ##1 !overcurrent_irq);
    c_sleep_on: cover property (drive.reg_on && power_state == ldo2_pkg::PS_SLEEP);

endmodule // ldo2_enable_fault_control

/* verification/load_model.sv */
// regulator load and overcurrent comparator stand-in
`timescale 1ns/10ps
module load_model (
    input  wire logic ref_clk,
    input  wire logic rst,
    input  wire logic reg_on,
    input  wire logic overload,
    output logic      overcurrent_pin
);
    // comparator only trips while the pass device drives into the overload
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            overcurrent_pin <= 1'b0;
        end else begin
            overcurrent_pin <= reg_on & overload;
        end
    end
endmodule // load_model

/* verification/test_ldo2_enable_fault_control.sv */
// self-checking bench for the regulator enable and fault control block
`timescale 1ns/10ps
module test_ldo2_enable_fault_control;
    logic                   ref_clk = 1'b0;
    logic                   rst = 1'b1;
    logic                   ce = 1'b1;
    logic [7:0]             addr = 8'h00;
    logic [7:0]             wdata = 8'h00;
    logic                   wr = 1'b0;
    logic                   rd = 1'b0;
    logic [7:0]             rdata;
    ldo2_pkg::power_state_t power_state = ldo2_pkg::PS_RUN;
    logic                   processor_reset_out_n = 1'b1;
    logic                   overcurrent_pin;
    logic                   overload = 1'b0;
    ldo2_pkg::drive_t       drive;
    logic [3:0]             voltage_code;
    logic [11:0]            setpoint_mv;
    logic                   irq;
    logic [31:0]            lfsr = 32'h4f630699;
    int                     num_errors = 0;
    int                     num_checks = 0;
    int                     m_ctrl = 0;
    int                     m_stat = 0;
    int                     m_mask = 0;

    ldo2_enable_fault_control dut (
        .ref_clk(ref_clk), .rst(rst), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .power_state(power_state), .processor_reset_out_n(processor_reset_out_n),
        .overcurrent_pin(overcurrent_pin), .drive(drive), .voltage_code(voltage_code),
        .setpoint_mv(setpoint_mv), .irq(irq));

    load_model u_load (.ref_clk(ref_clk), .rst(rst), .reg_on(drive.reg_on), .overload(overload),
        .overcurrent_pin(overcurrent_pin));

    // free-running 20 MHz clock
    always #25 ref_clk = ~ref_clk;

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // expected {reg_on, low_power_mode, discharge_on} from state, control bits and reset pin
    function automatic logic [2:0] model_drive(input int ps, input int c, input logic prn);
        logic on;
        logic lp;
        on = c[0] && (ps == 0 || (ps == 1 && c[1]) || (ps == 2 && c[2]));
        lp = on && ps != 0 && c[3];
        return {on, lp, !on || !prn};
    endfunction

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic bus_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge ref_clk);
        wr <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe, so sample just past that edge
    task automatic bus_read(input logic [7:0] a, input logic [7:0] exp);
        @(posedge ref_clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge ref_clk);
        rd <= 1'b0;
        #1;
        check({8'h00, rdata}, {8'h00, exp});
    endtask

    // drive lags its causes by one edge; two edges leave margin
    task automatic settle_and_check(input int ps);
        logic [2:0] md;
        repeat (2) @(posedge ref_clk);
        #1;
        md = model_drive(ps, m_ctrl, processor_reset_out_n);
        check({13'h0, drive}, {13'h0, md});
        check({15'h0, irq}, {15'h0, (m_stat & ~m_mask & 1) != 0});
        // the comparator level stays up while an unprotected output drives the overload
        bus_read(ldo2_pkg::OFS_STATE, {4'h0, overload && md[2], md});
    endtask

    // one overload episode in run state, with protection and mask as given
    task automatic run_overload(input logic protect, input logic masked);
        m_mask = masked;
        bus_write(ldo2_pkg::OFS_MASK, {7'h0, masked});
        m_ctrl = protect ? 8'h11 : 8'h01;
        bus_write(ldo2_pkg::OFS_CTRL, m_ctrl[7:0]);
        @(posedge ref_clk);
        overload <= 1'b1;
        repeat (12) @(posedge ref_clk);
        m_stat = 1;
        m_ctrl = protect ? 8'h10 : 8'h01;
        settle_and_check(0);
        @(posedge ref_clk);
        overload <= 1'b0;
        repeat (8) @(posedge ref_clk);
        bus_read(ldo2_pkg::OFS_STATUS, 8'h01);
        bus_read(ldo2_pkg::OFS_CTRL, m_ctrl[7:0]);
        m_mask = 0;
        bus_write(ldo2_pkg::OFS_MASK, 8'h00);
        settle_and_check(0);
        m_stat = 0;
        bus_write(ldo2_pkg::OFS_STATUS, 8'h01);
        settle_and_check(0);
    endtask

    task automatic give_verdict;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // watchdog: the sequence needs about 900 cycles
    initial begin
        repeat (8000) @(posedge ref_clk);
        num_errors++;
        give_verdict();
    end

    initial begin
        repeat (4) @(posedge ref_clk);
        rst <= 1'b0;
        #1;
        check({13'h0, drive}, {13'h0, ldo2_pkg::DRIVE_RESET});
        check({4'h0, setpoint_mv}, 16'h0708);
        check({15'h0, irq}, 16'h0000);
        bus_read(ldo2_pkg::OFS_CTRL, 8'h00);
        bus_read(ldo2_pkg::OFS_STATUS, 8'h00);
        bus_read(8'h07, 8'h00);
        // every power state, including the illegal one, against every low control nibble
        for (int ps = 0; ps < 4; ps++) begin
            for (int c = 0; c < 16; c++) begin
                lfsr = lfsr_next(lfsr);
                @(posedge ref_clk);
                power_state <= ldo2_pkg::power_state_t'(ps[1:0]);
                processor_reset_out_n <= lfsr[0];
                m_ctrl = c;
                bus_write(ldo2_pkg::OFS_CTRL, {lfsr[7:5], 1'b0, c[3:0]});
                settle_and_check(ps);
                bus_read(ldo2_pkg::OFS_CTRL, c[7:0]);
            end
        end
        // all sixteen set-point codes
        for (int v = 0; v < 16; v++) begin
            bus_write(ldo2_pkg::OFS_VOLT, {4'h0, v[3:0]});
            repeat (2) @(posedge ref_clk);
            #1;
            check({12'h0, voltage_code}, 16'(v));
            check({4'h0, setpoint_mv}, 16'(1800 + 100 * v));
            bus_read(ldo2_pkg::OFS_VOLT, v[7:0]);
        end
        @(posedge ref_clk);
        power_state <= ldo2_pkg::PS_RUN;
        processor_reset_out_n <= 1'b1;
        for (int k = 0; k < 4; k++) begin
            run_overload(k[1], k[0]);
        end
        // writes to unmapped and read-only places, and with the clock enable low
        bus_write(8'h10, 8'hff);
        bus_write(ldo2_pkg::OFS_STATE, 8'hff);
        bus_read(8'h10, 8'h00);
        @(posedge ref_clk);
        ce <= 1'b0;
        bus_write(ldo2_pkg::OFS_CTRL, 8'h0f);
        @(posedge ref_clk);
        ce <= 1'b1;
        bus_read(ldo2_pkg::OFS_CTRL, m_ctrl[7:0]);
        settle_and_check(0);
        // a second reset in mid-run must drop the protection bit left set above
        @(posedge ref_clk);
        rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        #1;
        check({13'h0, drive}, {13'h0, ldo2_pkg::DRIVE_RESET});
        check({4'h0, setpoint_mv}, 16'h0708);
        m_ctrl = 0;
        bus_read(ldo2_pkg::OFS_CTRL, 8'h00);
        give_verdict();
    end
endmodule // test_ldo2_enable_fault_control
